//--- logon_alignment_framer.sv
module logon_alignment_framer #(
    parameter int CW_TICK_CYCLES = logon_pkg::CW_TICK_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic      [15:0] reg_rdata,
    input  wire logic        tbl_superframe,
    input  wire logic        tbl_frame,
    input  wire logic        tbl_broadcast,
    input  wire logic        tbl_burst_plan,
    input  wire logic        logon_slot,
    input  wire logic        fl_valid,
    input  wire logic [47:0] fl_dst,
    input  wire logic        fl_resp,
    input  wire logic [3:0]  fl_resp_status,
    input  wire logic        fl_cw,
    input  wire logic [15:0] fl_cw_ms,
    input  wire logic        fl_success,
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    output logic             tx_last,
    input  wire logic        tx_ready,
    output logic             cw_on,
    output logic             confirmed
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_SLOT,
        ST_SEND
    } state_t;

    typedef struct packed {
        state_t      st;
        logic [1:0]  mode;
        logic [1:0]  mode_req;
        logic        pend;
        logic        conf;
        logic [3:0]  tables;
        logic [7:0]  eirp;
        logic [2:0]  flags;
        logic [15:0] pattern;
        logic [7:0]  slot_len;
        logic [47:0] hwid;
        logic [7:0]  pos;
        logic [1:0]  ph;
        logic [3:0]  esz;
        logic [7:0]  data;
        logic        last;
        logic [15:0] cw_ms;
        logic [31:0] tick_cnt;
        logic [15:0] rdata;
    } core_t;

    core_t s_reg;
    core_t s_next;

    ////////////////////////////////////////////////////////////////////////////
    // one byte of the frame from position and element phase
    function automatic logic [7:0] frame_byte(
        input logic [1:0]  mode,
        input logic        conf,
        input logic [7:0]  pos,
        input logic [1:0]  ph,
        input logic [7:0]  rem,
        input logic [7:0]  eirp,
        input logic [2:0]  flags,
        input logic [15:0] pat
    );
        logic [7:0] b;
        b = 8'h00;
        if (pos == 8'h00) begin
            if (mode == logon_pkg::MODE_INSTALL) begin
                b = {logon_pkg::ENTRY_INSTALL, logon_pkg::STATUS_INSTALL};
            end else if (mode == logon_pkg::MODE_OPER || conf) begin
                b = {logon_pkg::ENTRY_OPER, 3'h0, conf};
            end else begin
                b = {logon_pkg::ENTRY_ALIGN_REQ, 3'h0, conf};
            end
        end else if (mode != logon_pkg::MODE_INSTALL) begin
            // fixed capability element after the header
            case (pos)
                8'h01:   b = {logon_pkg::ELEM_CAP_TYPE, logon_pkg::ELEM_CAP_SIZE};
                8'h02:   b = eirp;
                default: b = {5'h00, flags};
            endcase
        end else begin
            case (ph)
                2'h0: begin
                    if (rem == 8'h01) begin
                        b = pat[15:8];
                    end else if (rem >= 8'h03) begin
                        b = {logon_pkg::ELEM_IB_TYPE, logon_pkg::ELEM_IB_FULL};
                    end else begin
                        b = {logon_pkg::ELEM_IB_TYPE, logon_pkg::ELEM_IB_SHORT};
                    end
                end
                2'h1:    b = pat[15:8];
                default: b = pat[7:0];
            endcase
        end
        return b;
    endfunction

    // bytes left in the slot counting the current one
    function automatic logic [7:0] bytes_left(input logic [7:0] len, input logic [7:0] pos);
        return len - pos;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic        addr_ok;
    logic        go_wr;
    logic [1:0]  eff_mode;
    logic [7:0]  last_pos;
    logic [7:0]  rem_now;
    logic [7:0]  rem_nxt;
    logic [7:0]  pos_nxt;
    logic [1:0]  ph_nxt;
    logic [3:0]  esz_nxt;
    logic        tick;

    // forward descriptors count only when addressed to our hardware id
    assign addr_ok = fl_valid && (fl_dst == s_reg.hwid);
    assign go_wr   = reg_we && (reg_addr == logon_pkg::REG_CTRL)
                     && reg_wdata[logon_pkg::CTRL_GO_BIT];
    assign tick    = (s_reg.tick_cnt == 32'(CW_TICK_CYCLES - 1));

    always_comb begin
        s_next   = s_reg;
        eff_mode = s_reg.mode;
        last_pos = (s_reg.mode == logon_pkg::MODE_INSTALL) ? s_reg.slot_len - 8'h01
                                                          : logon_pkg::CAP_LAST_POS;
        rem_now  = bytes_left(s_reg.slot_len, s_reg.pos);
        pos_nxt  = s_reg.pos + 8'h01;
        rem_nxt  = bytes_left(s_reg.slot_len, pos_nxt);
        ph_nxt   = 2'h0;
        esz_nxt  = s_reg.esz;

        // element phase walk: header, upper byte, lower byte
        if (s_reg.pos != 8'h00) begin
            case (s_reg.ph)
                2'h0: begin
                    esz_nxt = (rem_now >= 8'h03) ? logon_pkg::ELEM_IB_FULL
                                                 : logon_pkg::ELEM_IB_SHORT;
                    ph_nxt  = (rem_now == 8'h01) ? 2'h0 : 2'h1;
                end
                2'h1:    ph_nxt = (s_reg.esz == logon_pkg::ELEM_IB_FULL) ? 2'h2 : 2'h0;
                default: ph_nxt = 2'h0;
            endcase
        end

        // register writes
        if (reg_we) begin
            case (reg_addr)
                logon_pkg::REG_CTRL: begin
                    if (reg_wdata[logon_pkg::CTRL_CLR_CONF]) begin
                        s_next.conf = 1'b0;
                    end
                    if (reg_wdata[logon_pkg::CTRL_CLR_TABLES]) begin
                        s_next.tables = 4'h0;
                    end
                    if (reg_wdata[logon_pkg::CTRL_GO_BIT]) begin
                        s_next.pend     = 1'b1;
                        s_next.mode_req = reg_wdata[logon_pkg::CTRL_MODE_LSB +: 2];
                    end
                end
                logon_pkg::REG_CAP: begin
                    s_next.eirp  = reg_wdata[7:0];
                    s_next.flags = reg_wdata[10:8];
                end
                logon_pkg::REG_PATTERN:  s_next.pattern = reg_wdata;
                logon_pkg::REG_SLOT_LEN: begin
                    // a zero-length slot would wrap the byte walk
                    s_next.slot_len = (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
                end
                logon_pkg::REG_HWID_LO:  s_next.hwid[15:0]  = reg_wdata;
                logon_pkg::REG_HWID_MID: s_next.hwid[31:16] = reg_wdata;
                logon_pkg::REG_HWID_HI:  s_next.hwid[47:32] = reg_wdata;
                default: ;
            endcase
        end

        // forward tables are sticky, set wins over a clear
        if (tbl_superframe) s_next.tables[0] = 1'b1;
        if (tbl_frame)      s_next.tables[1] = 1'b1;
        if (tbl_broadcast)  s_next.tables[2] = 1'b1;
        if (tbl_burst_plan) s_next.tables[3] = 1'b1;

        // response status bit 0 decides confirmation; a zero revokes it
        if (addr_ok && fl_resp) begin
            s_next.conf = fl_resp_status[0];
        end
        // success: confirm and queue an operational logon
        if (addr_ok && fl_success) begin
            s_next.conf     = 1'b1;
            s_next.pend     = 1'b1;
            s_next.mode_req = logon_pkg::MODE_OPER;
        end

        // cw timer in millisecond ticks; a new descriptor adds time
        s_next.tick_cnt = (tick || s_reg.cw_ms == 16'h0000) ? 32'h0 : s_reg.tick_cnt + 32'h1;
        if (tick && s_reg.cw_ms != 16'h0000) begin
            s_next.cw_ms = s_reg.cw_ms - 16'h0001;
        end
        if (addr_ok && fl_cw) begin
            if (s_reg.cw_ms == 16'h0000) begin
                s_next.cw_ms = fl_cw_ms;
            end else begin
                // saturate rather than wrap a long extension
                s_next.cw_ms = (s_next.cw_ms > 16'hFFFF - fl_cw_ms) ? 16'hFFFF
                                                                   : s_next.cw_ms + fl_cw_ms;
            end
        end

        // logon sequencer
        case (s_reg.st)
            ST_IDLE: begin
                if (s_reg.pend && (&s_reg.tables)) begin
                    s_next.pend = go_wr || (addr_ok && fl_success);
                    s_next.mode = s_reg.mode_req;
                    s_next.st   = ST_WAIT_SLOT;
                end
            end
            ST_WAIT_SLOT: begin
                if (logon_slot) begin
                    eff_mode    = s_reg.mode;
                    s_next.pos  = 8'h00;
                    s_next.ph   = 2'h0;
                    s_next.data = frame_byte(eff_mode, s_reg.conf, 8'h00, 2'h0,
                                             s_reg.slot_len, s_reg.eirp, s_reg.flags,
                                             s_reg.pattern);
                    s_next.last = (last_pos == 8'h00);
                    s_next.st   = ST_SEND;
                end
            end
            ST_SEND: begin
                if (tx_ready) begin
                    if (s_reg.last) begin
                        s_next.st = ST_IDLE;
                    end else begin
                        s_next.pos  = pos_nxt;
                        s_next.ph   = ph_nxt;
                        s_next.esz  = esz_nxt;
                        s_next.data = frame_byte(s_reg.mode, s_reg.conf, pos_nxt, ph_nxt,
                                                 rem_nxt, s_reg.eirp, s_reg.flags,
                                                 s_reg.pattern);
                        s_next.last = (pos_nxt == last_pos);
                    end
                end
            end
            default: s_next.st = ST_IDLE;
        endcase

        // read data stands the cycle after the strobe
        s_next.rdata = 16'h0000;
        if (reg_re) begin
            case (reg_addr)
                logon_pkg::REG_CTRL:      s_next.rdata = {14'h0000, s_reg.mode_req};
                logon_pkg::REG_CAP:       s_next.rdata = {5'h00, s_reg.flags, s_reg.eirp};
                logon_pkg::REG_PATTERN:   s_next.rdata = s_reg.pattern;
                logon_pkg::REG_SLOT_LEN:  s_next.rdata = {8'h00, s_reg.slot_len};
                logon_pkg::REG_HWID_LO:   s_next.rdata = s_reg.hwid[15:0];
                logon_pkg::REG_HWID_MID:  s_next.rdata = s_reg.hwid[31:16];
                logon_pkg::REG_HWID_HI:   s_next.rdata = s_reg.hwid[47:32];
                logon_pkg::REG_STATUS: begin
                    s_next.rdata = {6'h00, s_reg.st, s_reg.tables, s_reg.pend,
                                    (s_reg.cw_ms != 16'h0000), (&s_reg.tables), s_reg.conf};
                end
                logon_pkg::REG_CW_REMAIN: s_next.rdata = s_reg.cw_ms;
                default:                  s_next.rdata = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg          <= '0;
            s_reg.st       <= ST_IDLE;
            s_reg.slot_len <= logon_pkg::SLOT_LEN_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata = s_reg.rdata;
    assign tx_data   = s_reg.data;
    assign tx_valid  = (s_reg.st == ST_SEND);
    assign tx_last   = (s_reg.st == ST_SEND) && s_reg.last;
    assign cw_on     = (s_reg.cw_ms != 16'h0000);
    assign confirmed = s_reg.conf;
endmodule

//--- logon_pkg.sv
package logon_pkg;
    // register port layout
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 16;
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_CAP       = 4'h1;
    localparam logic [3:0]  REG_PATTERN   = 4'h2;
    localparam logic [3:0]  REG_SLOT_LEN  = 4'h3;
    localparam logic [3:0]  REG_HWID_LO   = 4'h4;
    localparam logic [3:0]  REG_HWID_MID  = 4'h5;
    localparam logic [3:0]  REG_HWID_HI   = 4'h6;
    localparam logic [3:0]  REG_STATUS    = 4'h7;
    localparam logic [3:0]  REG_CW_REMAIN = 4'h8;

    // control register fields
    localparam int CTRL_GO_BIT      = 0;
    localparam int CTRL_MODE_LSB    = 1;
    localparam int CTRL_CLR_CONF    = 3;
    localparam int CTRL_CLR_TABLES  = 4;

    // logon modes
    typedef enum logic [1:0] {
        MODE_ALIGN_REQ = 2'h0,
        MODE_OPER      = 2'h1,
        MODE_INSTALL   = 2'h2
    } mode_t;

    // header nibbles, capability last position, reset slot length
    localparam logic [3:0] ENTRY_ALIGN_REQ = 4'h0;
    localparam logic [3:0] ENTRY_OPER      = 4'h1;
    localparam logic [3:0] ENTRY_INSTALL   = 4'h5;
    localparam logic [3:0] STATUS_INSTALL  = 4'h0;
    localparam logic [3:0] ELEM_CAP_TYPE   = 4'hA;
    localparam logic [3:0] ELEM_CAP_SIZE   = 4'h2;
    localparam logic [3:0] ELEM_IB_TYPE    = 4'hB;
    localparam logic [3:0] ELEM_IB_FULL    = 4'h2;
    localparam logic [3:0] ELEM_IB_SHORT   = 4'h1;
    localparam logic [7:0] CAP_LAST_POS    = 8'h03;
    localparam logic [7:0] SLOT_LEN_RESET  = 8'h10;

    // timing: cw duration counted in milliseconds
    localparam int CLK_HZ        = 40_000_000;
    localparam int CW_TICK_US    = 1000;
    localparam int CW_TICK_CYC   = CLK_HZ / 1_000_000 * CW_TICK_US;
endpackage

//--- logon_framer_checker_properties.sv
module logon_framer_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        reg_re,
    input wire logic [15:0] reg_rdata,
    input wire logic        logon_slot,
    input wire logic        fl_valid,
    input wire logic        fl_cw,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    input wire logic        tx_last,
    input wire logic        tx_ready,
    input wire logic        cw_on,
    input wire logic        confirmed
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    //////////////////////////////////////////////////////////////////////
    // read port and stream framing
    property p_rd_zero; !$past(reg_re) |-> reg_rdata == 16'h0000; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
    a_hold: assert property (p_hold) else $error("byte lost under stall");
    property p_drop; tx_valid && tx_ready && tx_last |=> !tx_valid; endproperty
    a_drop: assert property (p_drop) else $error("frame runs past last byte");
    property p_last_v; tx_last |-> tx_valid; endproperty
    a_last_v: assert property (p_last_v) else $error("last without valid");
    // a frame only opens in a granted slot
    property p_start; $rose(tx_valid) |-> $past(logon_slot); endproperty
    a_start: assert property (p_start) else $error("frame outside slot");
    //////////////////////////////////////////////////////////////////////
    // header byte contents
    property p_entry; $rose(tx_valid) |-> tx_data[7:4] inside {4'h0, 4'h1, 4'h5}; endproperty
    a_entry: assert property (p_entry) else $error("bad entry type");
    property p_ib_stat; $rose(tx_valid) && tx_data[7:4] == 4'h5 |-> tx_data[3:0] == 4'h0;
    endproperty
    a_ib_stat: assert property (p_ib_stat) else $error("burst status not zero");
    property p_conf; $rose(tx_valid) && tx_data[7:5] == 3'h0 |-> tx_data[3:0] == {3'h0, confirmed};
    endproperty
    a_conf: assert property (p_conf) else $error("status bit differs from flag");
    property p_cap; $rose(tx_valid) && tx_ready && tx_data[7:5] == 3'h0 |=> tx_data == 8'hA2;
    endproperty
    a_cap: assert property (p_cap) else $error("capability header missing");
    // cw only starts from a descriptor
    property p_cw; $rose(cw_on) |-> $past(fl_valid) && $past(fl_cw); endproperty
    a_cw: assert property (p_cw) else $error("cw started without descriptor");
endmodule
bind logon_alignment_framer logon_framer_checker u_chk (.clk(clk), .rst(rst), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .logon_slot(logon_slot), .fl_valid(fl_valid), .fl_cw(fl_cw),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .cw_on(cw_on), .confirmed(confirmed));

//--- ncc_model.sv
module ncc_model (
    input wire logic       clk,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_last,
    input wire logic       stall,
    output logic           tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    logic       phase_reg = 1'b0;
    int         last_at   = 0;
    // under stall the slow receiver accepts every other cycle only
    assign tx_ready = !stall || phase_reg;
    // collect burst bytes, header nibbles and elements alike
    always @(posedge clk) begin
        phase_reg <= !phase_reg;
        if (tx_valid && tx_ready) begin
            // remember which byte carried the end mark
            if (tx_last) last_at = got.size() + 1;
            got.push_back(tx_data);
        end
    end
endmodule

//--- testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0, logon_slot = 1'b0;
    logic [3:0] reg_addr = 4'h0, tbl = 4'h0, fl_st = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, fl_ms = 16'h0000, reg_rdata;
    logic fl_valid = 1'b0, fl_resp = 1'b0, fl_cw = 1'b0, fl_ok = 1'b0, stall = 1'b0;
    logic [47:0] fl_dst = 48'h0;
    logic [7:0] tx_data;
    logic tx_valid, tx_last, tx_ready, cw_on, confirmed;
    int failures = 0, n_checks = 0;
    localparam logic [47:0] HWID = 48'h1111_2222_3344;
    initial forever #12.5 clk = ~clk;
    logon_alignment_framer #(.CW_TICK_CYCLES(4)) u_dut (.clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .tbl_superframe(tbl[0]), .tbl_frame(tbl[1]),
        .tbl_broadcast(tbl[2]), .tbl_burst_plan(tbl[3]), .logon_slot(logon_slot),
        .fl_valid(fl_valid), .fl_dst(fl_dst), .fl_resp(fl_resp), .fl_resp_status(fl_st),
        .fl_cw(fl_cw), .fl_cw_ms(fl_ms), .fl_success(fl_ok), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .cw_on(cw_on),
        .confirmed(confirmed));
    ncc_model u_ncc (.clk(clk), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .stall(stall), .tx_ready(tx_ready));
    //////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a; reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // one-cycle descriptor aimed at a given hardware id
    task automatic fl(input logic [47:0] d, input logic r, input logic [3:0] s,
                      input logic c, input logic [15:0] m, input logic k);
        @(posedge clk);
        fl_valid <= 1'b1; fl_dst <= d; fl_resp <= r; fl_st <= s;
        fl_cw <= c; fl_ms <= m; fl_ok <= k;
        @(posedge clk);
        fl_valid <= 1'b0;
        // step past the taking edge so flags read next are already updated
        #1;
    endtask
    // grant a slot and compare n bytes against the packed expectation
    task automatic frame(input int n, input logic [63:0] e);
        int w;
        repeat (3) @(posedge clk);
        logon_slot <= 1'b1;
        @(posedge clk);
        logon_slot <= 1'b0;
        w = 0;
        while (u_ncc.got.size() < n && w < 200) begin
            @(posedge clk);
            w++;
        end
        chk(16'(u_ncc.got.size()), 16'(n));
        chk(16'(u_ncc.last_at), 16'(n));
        u_ncc.last_at = 0;
        for (int i = 0; i < n && i < u_ncc.got.size(); i++) chk({8'h00, u_ncc.got[i]},
            {8'h00, e[63-8*i -: 8]});
        u_ncc.got.delete();
        $display("test done, frame of %0d bytes", n);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // register defaults, unmapped place, zero length clamp
        rd(logon_pkg::REG_SLOT_LEN, 16'h0010);
        rd(4'hF, 16'h0000);
        wr(logon_pkg::REG_SLOT_LEN, 16'h0000);
        rd(logon_pkg::REG_SLOT_LEN, 16'h0001);
        wr(logon_pkg::REG_HWID_LO, 16'h3344);
        wr(logon_pkg::REG_HWID_MID, 16'h2222);
        wr(logon_pkg::REG_HWID_HI, 16'h1111);
        wr(logon_pkg::REG_PATTERN, 16'hC35A);
        wr(logon_pkg::REG_CAP, 16'h0000);
        // go before the tables arrive: slot must be ignored
        wr(logon_pkg::REG_CTRL, 16'h0001);
        repeat (3) @(posedge clk);
        logon_slot <= 1'b1;
        @(posedge clk);
        logon_slot <= 1'b0;
        repeat (5) @(posedge clk);
        chk({15'h0, tx_valid}, 16'h0000);
        tbl <= 4'hF;
        @(posedge clk);
        tbl <= 4'h0;
        frame(4, 64'h00A2_0000_0000_0000);
        // response for another terminal is ignored, ours confirms
        fl(48'h0000_0000_0001, 1'b1, 4'h1, 1'b0, 16'h0000, 1'b0);
        chk({15'h0, confirmed}, 16'h0000);
        fl(HWID, 1'b1, 4'h1, 1'b0, 16'h0000, 1'b0);
        chk({15'h0, confirmed}, 16'h0001);
        wr(logon_pkg::REG_CTRL, 16'h0001);
        frame(4, 64'h11A2_0000_0000_0000);
        // burst fill, one spare byte then two spare bytes under stall
        wr(logon_pkg::REG_SLOT_LEN, 16'h0005);
        wr(logon_pkg::REG_CTRL, 16'h0005);
        frame(5, 64'h50B2_C35A_C300_0000);
        stall <= 1'b1;
        wr(logon_pkg::REG_SLOT_LEN, 16'h0006);
        wr(logon_pkg::REG_CTRL, 16'h0005);
        frame(6, 64'h50B2_C35A_B1C3_0000);
        stall <= 1'b0;
        // cw of 2 ms extended by 3 ms mid-run
        fl(HWID, 1'b0, 4'h0, 1'b1, 16'h0002, 1'b0);
        repeat (3) @(posedge clk);
        fl(HWID, 1'b0, 4'h0, 1'b1, 16'h0003, 1'b0);
        repeat (8) @(posedge clk);
        chk({15'h0, cw_on}, 16'h0001);
        repeat (30) @(posedge clk);
        chk({15'h0, cw_on}, 16'h0000);
        rd(logon_pkg::REG_CW_REMAIN, 16'h0000);
        $display("test done, cw");
        // clear confirmation, then success queues an operational logon
        wr(logon_pkg::REG_CTRL, 16'h0008);
        rd(logon_pkg::REG_STATUS, 16'h00F2);
        fl(HWID, 1'b0, 4'h0, 1'b0, 16'h0000, 1'b1);
        chk({15'h0, confirmed}, 16'h0001);
        frame(4, 64'h11A2_0000_0000_0000);
        // centre disregards the confirmation and answers with status zero
        fl(HWID, 1'b1, 4'h0, 1'b0, 16'h0000, 1'b0);
        chk({15'h0, confirmed}, 16'h0000);
        $display("test done, confirmation revoked");
        tally_and_finish;
    end
endmodule
